/* rtl/pmdt_pkg.sv */
// constants and types for the power-mode direct-transfer controller
// assumes one system clock (the oscillator clock) and a plain register port
package pmdt_pkg;

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_IEN2 = 3'h1;
  localparam logic [2:0] ADDR_MODE = 3'h2;
  localparam logic [2:0] ADDR_ISTAT = 3'h3;
  localparam logic [2:0] ADDR_IMASK = 3'h4;

  // control register fields
  localparam int CTRL_STANDBY_SELECT = 0;
  localparam int CTRL_LOW_SPEED_ON = 1;
  localparam int CTRL_MEDIUM_SPEED_ON = 2;
  localparam int CTRL_DIRECT_TRANSFER_ENABLE = 3;
  localparam int CTRL_TIMER_A_CLOCK_SELECT = 4;
  localparam int CTRL_STS_LSB = 5;
  localparam int STS_W = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int IEN2_DT = 0;
  localparam logic IEN2_RST = 1'h0;
  localparam int MODE_BUSY = 3;

  // ----------------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------------
  localparam int EV_W = 4;
  localparam int EV_DT_DONE = 0;
  localparam int EV_LOWPWR = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_IGNORED = 3;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;

  // ----------------------------------------------------------------------
  // timing, in oscillator clocks and in system states
  // ----------------------------------------------------------------------
  localparam int HIGH_DIV = 2;
  localparam int MED_RATIO = 8;
  localparam int MED_DIV = HIGH_DIV * MED_RATIO;
  localparam int SUB_DIV = 16;
  localparam int DIV_W = 5;
  localparam int SLEEP_STATES = 2;
  localparam int INTPROC_STATES = 1;
  localparam int PRE_STATES = SLEEP_STATES + INTPROC_STATES;
  localparam int EXC_STATES = 14;
  localparam int SETTLE_LONG_STATES = 8192;
  localparam int CNT_W = 14;
  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;

  // ----------------------------------------------------------------------
  // modes, clock rates and transfer phases
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_HIGH = 3'b000,
    MODE_MED = 3'b001,
    MODE_SUB = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_WATCH = 3'b100,
    MODE_STANDBY = 3'b101,
    MODE_SUBSLEEP = 3'b110
  } pmdt_mode_t;

  typedef enum logic [1:0] {
    RATE_HIGH = 2'b00,
    RATE_MED = 2'b01,
    RATE_SUB = 2'b10
  } pmdt_rate_t;

  typedef enum logic [2:0] {
    PH_RUN = 3'b000,
    PH_PRE = 3'b001,
    PH_SETTLE = 3'b010,
    PH_EXC = 3'b011,
    PH_HALT = 3'b100
  } pmdt_phase_t;

endpackage

/* rtl/pmdt_tick.sv */
// system-state tick generator for the selected cpu clock rate
// assumes clk_in is the undivided oscillator clock
module pmdt_tick
  import pmdt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // rate select
  input wire pmdt_rate_t rate_in,
  // ticks
  output logic tick_out,
  output logic tone_tick_out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    pmdt_rate_t rate;
    logic tick;
    logic tone;
  } pmdt_tick_st_t;

  pmdt_tick_st_t s_q, s_d;
  logic [DIV_W-1:0] last;

  always_comb begin
    s_d = s_q;
    unique case (s_q.rate)
      RATE_HIGH: last = DIV_W'(HIGH_DIV - 1);
      RATE_MED: last = DIV_W'(MED_DIV - 1);
      RATE_SUB: last = DIV_W'(SUB_DIV - 1);
      default: last = DIV_W'(HIGH_DIV - 1);
    endcase
    // tone generator stays on the undivided clock in every active rate
    s_d.tone = 1'b1;
    if (rate_in != s_q.rate) begin
      s_d.rate = rate_in;
      s_d.cnt = '0;
      s_d.tick = 1'b0;
    end else if (s_q.cnt == last) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + DIV_W'(1);
      s_d.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '{cnt: '0, rate: RATE_HIGH, tick: 1'b0, tone: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;
  assign tone_tick_out = s_q.tone;

endmodule

/* rtl/pmdt_irq.sv */
// sticky event status, mask and level interrupt
// assumes event pulses and the read-clear strobe are synchronous to clk_in
module pmdt_irq
  import pmdt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // events and software access
  input wire logic [EV_W-1:0] event_in,
  input wire logic rd_clr_in,
  input wire logic mask_wr_in,
  input wire logic [EV_W-1:0] mask_in,
  // state
  output logic [EV_W-1:0] status_out,
  output logic [EV_W-1:0] mask_out,
  output logic irq_out
);

  typedef struct packed {
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic irq;
  } pmdt_irq_st_t;

  pmdt_irq_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    // a new event in the clearing read's cycle survives the clear
    s_d.stat = (rd_clr_in ? EV_RST : s_q.stat) | event_in;
    if (mask_wr_in) begin
      s_d.mask = mask_in;
    end
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '{stat: EV_RST, mask: EV_RST, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign status_out = s_q.stat;
  assign mask_out = s_q.mask;
  assign irq_out = s_q.irq;

endmodule

/* rtl/pmdt_ctrl.sv */
// power-mode controller with direct transfer among the running modes
// assumes the cpu pulses sleep_in for one cycle per sleep instruction,
// wake_in is an enabled wake interrupt request, imask_in the cpu mask bit
module pmdt_ctrl
  import pmdt_pkg::*;
#(
  parameter int SETTLE_STATES = SETTLE_LONG_STATES
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // cpu side
  input wire logic sleep_in,
  input wire logic wake_in,
  input wire logic imask_in,
  output logic cpu_clk_en_out,
  output logic dt_exc_start_out,
  // clocking and peripherals
  output logic tone_clk_en_out,
  output logic periph_halt_out,
  output logic timer_a_run_out,
  output logic [2:0] mode_out,
  // interrupt
  output logic irq_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic ien2;
    pmdt_mode_t mode;
    pmdt_mode_t target;
    pmdt_mode_t via;
    pmdt_phase_t phase;
    pmdt_rate_t rate;
    logic [CNT_W-1:0] cnt;
    logic dt;
    logic no_wake;
    logic [EV_W-1:0] ev;
    logic [DATA_W-1:0] rdata;
    logic cpu_en;
    logic exc_start;
    logic tone_en;
    logic halt;
    logic tma_run;
  } pmdt_st_t;

  pmdt_st_t s_q, s_d;

  logic tick;
  logic tone_tick;
  logic [EV_W-1:0] ev_stat;
  logic [EV_W-1:0] ev_mask;
  logic irq;
  logic standby_select, low_speed_on, medium_speed_on, direct_transfer_enable, timer_a_clock_select;
  logic [STS_W-1:0] sts;
  logic [CNT_W-1:0] settle_cnt;
  logic is_active, dt_ok;
  pmdt_mode_t dt_target, dt_via, lp_mode, wake_to;
  logic lp_ok, wake_settle;

  assign standby_select = s_q.ctrl[CTRL_STANDBY_SELECT];
  assign low_speed_on = s_q.ctrl[CTRL_LOW_SPEED_ON];
  assign medium_speed_on = s_q.ctrl[CTRL_MEDIUM_SPEED_ON];
  assign direct_transfer_enable = s_q.ctrl[CTRL_DIRECT_TRANSFER_ENABLE];
  assign timer_a_clock_select = s_q.ctrl[CTRL_TIMER_A_CLOCK_SELECT];
  assign sts = s_q.ctrl[CTRL_STS_LSB +: STS_W];
  // each step of the settling select halves the longest wait
  assign settle_cnt = CNT_W'(SETTLE_STATES >> sts);
  assign is_active = (s_q.mode == MODE_HIGH) || (s_q.mode == MODE_MED);

  // cpu clock rate that belongs to a running mode
  function automatic pmdt_rate_t rate_for(pmdt_mode_t m);
    pmdt_rate_t r;
    r = RATE_SUB;
    if (m == MODE_HIGH) begin
      r = RATE_HIGH;
    end else if (m == MODE_MED) begin
      r = RATE_MED;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // rate ticks and interrupt block
  // ----------------------------------------------------------------------
  pmdt_tick u_tick (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .rate_in(s_q.rate),
    .tick_out(tick),
    .tone_tick_out(tone_tick)
  );

  pmdt_irq u_irq (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .event_in(s_q.ev),
    .rd_clr_in(rd_in && (addr_in == ADDR_ISTAT)),
    .mask_wr_in(wr_in && (addr_in == ADDR_IMASK)),
    .mask_in(wdata_in[EV_W-1:0]),
    .status_out(ev_stat),
    .mask_out(ev_mask),
    .irq_out(irq)
  );

  // ----------------------------------------------------------------------
  // sleep decode
  // ----------------------------------------------------------------------
  always_comb begin
    dt_ok = 1'b0;
    dt_target = s_q.mode;
    dt_via = MODE_SLEEP;
    // the four transfer combinations, each needing the enable bit
    if (direct_transfer_enable) begin
      if (s_q.mode == MODE_HIGH && !standby_select && !low_speed_on && medium_speed_on) begin
        dt_ok = 1'b1;
        dt_target = MODE_MED;
      end else if (s_q.mode == MODE_MED && !standby_select && !low_speed_on && !medium_speed_on) begin
        dt_ok = 1'b1;
        dt_target = MODE_HIGH;
      end else if (is_active && standby_select && low_speed_on && timer_a_clock_select) begin
        dt_ok = 1'b1;
        dt_target = MODE_SUB;
        dt_via = MODE_WATCH;
      end else if (s_q.mode == MODE_SUB && standby_select && !low_speed_on && timer_a_clock_select) begin
        dt_ok = 1'b1;
        dt_target = medium_speed_on ? MODE_MED : MODE_HIGH;
        dt_via = MODE_WATCH;
      end
    end
    // ordinary entry when no transfer applies
    lp_ok = 1'b1;
    lp_mode = MODE_SLEEP;
    if (is_active && standby_select && timer_a_clock_select) begin
      lp_mode = MODE_WATCH;
    end else if (is_active && standby_select && !low_speed_on) begin
      lp_mode = MODE_STANDBY;
    end else if (is_active && !standby_select && !low_speed_on) begin
      lp_mode = MODE_SLEEP;
    end else if (s_q.mode == MODE_SUB && standby_select && timer_a_clock_select) begin
      lp_mode = MODE_WATCH;
    end else if (s_q.mode == MODE_SUB && !standby_select && low_speed_on && timer_a_clock_select) begin
      lp_mode = MODE_SUBSLEEP;
    end else begin
      lp_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // wake decode
  // ----------------------------------------------------------------------
  always_comb begin
    wake_to = medium_speed_on ? MODE_MED : MODE_HIGH;
    wake_settle = 1'b0;
    unique case (s_q.mode)
      MODE_STANDBY: wake_settle = 1'b1;
      MODE_WATCH: begin
        if (low_speed_on) begin
          wake_to = MODE_SUB;
        end else begin
          wake_settle = 1'b1;
        end
      end
      MODE_SUBSLEEP: wake_to = MODE_SUB;
      default: wake_settle = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ev = EV_RST;
    s_d.exc_start = 1'b0;
    unique case (s_q.phase)
      PH_RUN: begin
        if (sleep_in && dt_ok && s_q.ien2 && !imask_in) begin
          // transfer keeps running; count the old-rate states first
          s_d.phase = PH_PRE;
          s_d.target = dt_target;
          // keep the via mode; the control bits may change meanwhile
          s_d.via = dt_via;
          s_d.dt = 1'b1;
          s_d.cnt = CNT_W'(PRE_STATES - 1);
        end else if (sleep_in && dt_ok) begin
          s_d.phase = PH_HALT;
          s_d.mode = dt_via;
          s_d.no_wake = imask_in;
          s_d.ev[EV_LOWPWR] = 1'b1;
        end else if (sleep_in && lp_ok) begin
          s_d.phase = PH_HALT;
          s_d.mode = lp_mode;
          // an ordinary sleep never inherits a masked attempt's lock
          s_d.no_wake = 1'b0;
          s_d.ev[EV_LOWPWR] = 1'b1;
        end else if (sleep_in) begin
          s_d.ev[EV_IGNORED] = 1'b1;
        end
      end
      PH_PRE: begin
        if (tick) begin
          if (s_q.cnt == CNT_ZERO) begin
            s_d.phase = PH_SETTLE;
            s_d.mode = s_q.via;
            s_d.rate = rate_for(s_q.target);
            // only leaving subactive needs the oscillator to settle
            s_d.cnt = (s_q.mode == MODE_SUB) ? settle_cnt : CNT_ZERO;
          end else begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end
        end
      end
      PH_SETTLE: begin
        if (tick) begin
          if (s_q.cnt == CNT_ZERO) begin
            s_d.mode = s_q.target;
            if (s_q.dt) begin
              s_d.phase = PH_EXC;
              s_d.cnt = CNT_W'(EXC_STATES - 1);
              s_d.exc_start = 1'b1;
            end else begin
              s_d.phase = PH_RUN;
              s_d.ev[EV_WAKE] = 1'b1;
            end
          end else begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end
        end
      end
      PH_EXC: begin
        // the handler already runs at the new rate
        if (tick) begin
          if (s_q.cnt == CNT_ZERO) begin
            s_d.phase = PH_RUN;
            s_d.dt = 1'b0;
            s_d.ev[EV_DT_DONE] = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end
        end
      end
      PH_HALT: begin
        // a masked transfer attempt leaves only through reset
        if (wake_in && !imask_in && !s_q.no_wake) begin
          s_d.target = wake_to;
          s_d.rate = rate_for(wake_to);
          if (wake_settle) begin
            s_d.phase = PH_SETTLE;
            s_d.cnt = settle_cnt;
          end else begin
            s_d.phase = PH_RUN;
            s_d.mode = wake_to;
            s_d.ev[EV_WAKE] = 1'b1;
          end
        end
      end
      default: s_d.phase = PH_RUN;
    endcase

    // register writes and reads
    if (wr_in && addr_in == ADDR_CTRL) begin
      s_d.ctrl = wdata_in;
    end
    if (wr_in && addr_in == ADDR_IEN2) begin
      s_d.ien2 = wdata_in[IEN2_DT];
    end
    s_d.rdata = '0;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_CTRL: s_d.rdata = s_q.ctrl;
        ADDR_IEN2: s_d.rdata[IEN2_DT] = s_q.ien2;
        ADDR_MODE: begin
          s_d.rdata[2:0] = s_q.mode;
          s_d.rdata[MODE_BUSY] = (s_q.phase != PH_RUN);
        end
        ADDR_ISTAT: s_d.rdata[EV_W-1:0] = ev_stat;
        ADDR_IMASK: s_d.rdata[EV_W-1:0] = ev_mask;
        default: s_d.rdata = '0;
      endcase
    end

    // clock enables and peripheral control
    s_d.cpu_en = tick && (s_q.phase == PH_RUN || s_q.phase == PH_EXC);
    s_d.tone_en = tone_tick && (s_d.mode == MODE_HIGH ||
                                s_d.mode == MODE_MED);
    s_d.halt = (s_d.mode == MODE_WATCH) || (s_d.mode == MODE_STANDBY) ||
               (s_d.mode == MODE_SUBSLEEP);
    s_d.tma_run = (s_d.mode != MODE_STANDBY);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '{ctrl: CTRL_RST, ien2: IEN2_RST, mode: MODE_HIGH,
               target: MODE_HIGH, via: MODE_SLEEP, phase: PH_RUN,
               rate: RATE_HIGH, cnt: CNT_ZERO, dt: 1'b0, no_wake: 1'b0,
               ev: EV_RST, rdata: '0, cpu_en: 1'b0, exc_start: 1'b0,
               tone_en: 1'b0, halt: 1'b0, tma_run: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata_out = s_q.rdata;
  assign cpu_clk_en_out = s_q.cpu_en;
  assign dt_exc_start_out = s_q.exc_start;
  assign tone_clk_en_out = s_q.tone_en;
  assign periph_halt_out = s_q.halt;
  assign timer_a_run_out = s_q.tma_run;
  assign mode_out = s_q.mode;
  assign irq_out = irq;

endmodule

/* testbench/pmdt_monitor.sv */
// checker for the direct-transfer controller ports
// assumes the single clk_in domain; bound to every pmdt_ctrl
module pmdt_monitor
  import pmdt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // watched ports
  input wire logic rd_in,
  input wire logic imask_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic cpu_clk_en_out,
  input wire logic dt_exc_start_out,
  input wire logic tone_clk_en_out,
  input wire logic periph_halt_out,
  input wire logic timer_a_run_out,
  input wire logic [2:0] mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // cycles since reset release, saturating
  logic [1:0] up_q;
  logic [1:0] up_d;
  always_comb begin
    up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      up_q <= 2'h0;
    end else begin
      up_q <= up_d;
    end
  end

  tone_rate_a: assert property (
    up_q == 2'h3 && mode_out == $past(mode_out)
    |-> tone_clk_en_out == (mode_out <= 3'h1))
    else $error("tone enable does not follow the active modes");
  halt_level_a: assert property (
    periph_halt_out == (mode_out inside {3'h4, 3'h5, 3'h6}))
    else $error("peripheral halt does not match the mode");
  timer_run_a: assert property (
    timer_a_run_out == (mode_out != 3'h5))
    else $error("timer a stopped outside standby");
  read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside the answer cycle");
  exc_target_a: assert property (dt_exc_start_out
    |-> mode_out inside {3'h0, 3'h1, 3'h2} ##1 !dt_exc_start_out)
    else $error("exception start outside a running mode");
  exc_via_a: assert property (dt_exc_start_out
    |-> $past(mode_out) inside {3'h3, 3'h4})
    else $error("transfer skipped the via mode");
  high_rate_a: assert property (cpu_clk_en_out && mode_out == 3'h0
    |=> !cpu_clk_en_out)
    else $error("cpu states too close in high speed");
  halt_cpu_a: assert property (
    mode_out inside {3'h3, 3'h4, 3'h5, 3'h6}
    && $past(mode_out) == mode_out |-> !cpu_clk_en_out)
    else $error("cpu clocked in a halted mode");
  masked_hold_a: assert property (imask_in && mode_out == 3'h3
    |=> mode_out == 3'h3)
    else $error("masked sleep was left");

  cover property (dt_exc_start_out && mode_out == 3'h2);
  cover property (mode_out == 3'h4 ##1 mode_out == 3'h0);
  cover property (imask_in && mode_out == 3'h3);
endmodule

bind pmdt_ctrl pmdt_monitor mon_u (.clk_in, .resetn_in, .rd_in, .imask_in,
  .rdata_out, .cpu_clk_en_out, .dt_exc_start_out, .tone_clk_en_out,
  .periph_halt_out, .timer_a_run_out, .mode_out);

/* testbench/pmdt_cpu_model.sv */
// cpu core model: issues sleep instructions, mask bit and wake requests
// assumes clk_in is the controller's oscillator clock
module pmdt_cpu_model (
  // clock
  input wire logic clk_in,
  // controller side
  input wire logic cpu_clk_en_in,
  // cpu requests
  output logic sleep_out,
  output logic wake_out,
  output logic imask_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sleep_out = 1'b0;
    wake_out = 1'b0;
    imask_out = 1'b0;
  end
  // sleep lands on a cpu state boundary, one cycle long
  task automatic do_sleep();
    repeat (64) begin
      @(posedge clk_in);
      #1;
      if (cpu_clk_en_in === 1'b1) break;
    end
    @(posedge clk_in);
    sleep_out <= 1'b1;
    @(posedge clk_in);
    sleep_out <= 1'b0;
  endtask
  task automatic set_mask(logic v);
    @(posedge clk_in);
    imask_out <= v;
  endtask
  // wake is held at least two cycles so it cannot be missed
  task automatic wake(int n);
    @(posedge clk_in);
    wake_out <= 1'b1;
    repeat ((n < 2) ? 2 : n) @(posedge clk_in);
    wake_out <= 1'b0;
  endtask
endmodule

/* testbench/tb_power_mode_direct_transfer.sv */
// self-checking bench for the direct-transfer controller
// assumes the cpu model beside it and the monitor bound to the controller
module tb_power_mode_direct_transfer
  import pmdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 16;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic sleep_in;
  logic wake_in;
  logic imask_in;
  logic cpu_clk_en_out;
  logic dt_exc_start_out;
  logic tone_clk_en_out;
  logic periph_halt_out;
  logic timer_a_run_out;
  logic irq_out;
  logic [2:0] mode_out;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int exc_seen = 0;

  always #2 clk_in = ~clk_in;

  pmdt_ctrl #(.SETTLE_STATES(SETTLE)) dut_u (.clk_in, .resetn_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .sleep_in, .wake_in, .imask_in,
    .cpu_clk_en_out, .dt_exc_start_out, .tone_clk_en_out, .periph_halt_out,
    .timer_a_run_out, .mode_out, .irq_out);
  pmdt_cpu_model cpu_u (.clk_in, .cpu_clk_en_in(cpu_clk_en_out),
    .sleep_out(sleep_in), .wake_out(wake_in), .imask_out(imask_in));

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (dt_exc_start_out === 1'b1) exc_seen++;
    if (cycles == 40000) begin
      num_errors++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] rng(int v, int lo, int hi);
    return {7'h0, v >= lo && v <= hi};
  endfunction
  task automatic reg_wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_check(string name, logic [ADDR_W-1:0] a, logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(name, rdata_out, e);
  endtask
  task automatic wait_for(logic [2:0] m, output int n);
    n = 0;
    while (mode_out !== m && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask
  task automatic settle_ticks(int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic transfer(logic [7:0] ctrl, logic [2:0] via,
                          logic [2:0] tgt, int rate, int settle);
    int n;
    int t;
    reg_wr(ADDR_CTRL, ctrl);
    cpu_u.do_sleep();
    wait_for(via, n);
    check("via mode", {5'h0, mode_out}, {5'h0, via});
    check("via halt", {7'h0, periph_halt_out}, {7'h0, via == 3'h4});
    wait_for(tgt, n);
    check("settle", rng(n, settle*rate, (settle+1)*rate+16), 8'h1);
    check("exc start", {7'h0, dt_exc_start_out}, 8'h1);
    t = 0;
    while (irq_out !== 1'b1 && t < 1000) begin
      @(posedge clk_in);
      #1;
      t++;
    end
    check("exc time", rng(t, 14 * rate - 1, 14 * rate + 3), 8'h1);
    rd_check("status", ADDR_ISTAT, 8'h01);
    settle_ticks(1);
    check("irq", {7'h0, irq_out}, 8'h0);
    rd_check("mode", ADDR_MODE, {5'h0, tgt});
    check("tone", {7'h0, tone_clk_en_out}, {7'h0, tgt != 3'h2});
    wait_for(tgt, n);
    while (cpu_clk_en_out !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    t = 0;
    do begin
      @(posedge clk_in);
      #1;
      t++;
    end while (cpu_clk_en_out !== 1'b1 && t < 100);
    check("cpu rate", t[7:0], rate[7:0]);
  endtask

  task automatic low_power(logic [7:0] ctrl, logic [2:0] low,
                           logic [2:0] back);
    int n;
    int e;
    e = exc_seen;
    reg_wr(ADDR_CTRL, ctrl);
    cpu_u.do_sleep();
    wait_for(low, n);
    settle_ticks(2);
    check("irq masked", {7'h0, irq_out}, 8'h0);
    rd_check("low mode", ADDR_MODE, {5'h01, low});
    rd_check("low status", ADDR_ISTAT, 8'h02);
    cpu_u.wake(3);
    wait_for(back, n);
    check("woken", {5'h0, mode_out}, {5'h0, back});
    rd_check("wake status", ADDR_ISTAT, 8'h04);
    check("no exc", exc_seen[7:0], e[7:0]);
  endtask

  task automatic masked_then_reset();
    int n;
    cpu_u.set_mask(1'b1);
    reg_wr(ADDR_CTRL, 8'h0c);
    cpu_u.do_sleep();
    wait_for(3'h3, n);
    cpu_u.set_mask(1'b0);
    cpu_u.wake(20);
    settle_ticks(4);
    check("masked", {5'h0, mode_out}, 8'h03);
    rd_check("mask status", ADDR_ISTAT, 8'h02);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    cpu_u.set_mask(1'b0);
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    reset_values();
    reg_wr(ADDR_CTRL, 8'h03);
    cpu_u.do_sleep();
    settle_ticks(10);
    rd_check("refused", ADDR_ISTAT, 8'h08);
    rd_check("kept mode", ADDR_MODE, 8'h00);
  endtask

  task automatic reset_values();
    check("timer run", {7'h0, timer_a_run_out}, 8'h1);
    rd_check("ctrl", ADDR_CTRL, CTRL_RST);
    rd_check("ien2", ADDR_IEN2, 8'h00);
    rd_check("mode0", ADDR_MODE, 8'h00);
    rd_check("imask", ADDR_IMASK, 8'h00);
    reg_wr(3'h5, 8'hff);
    rd_check("unmapped", 3'h5, 8'h00);
  endtask

  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    reset_values();
    reg_wr(ADDR_IEN2, 8'h01);
    reg_wr(ADDR_IMASK, 8'h01);
    transfer(8'h0c, 3'h3, 3'h1, MED_DIV, 0);
    transfer(8'h08, 3'h3, 3'h0, HIGH_DIV, 0);
    transfer(8'h1b, 3'h4, 3'h2, SUB_DIV, 0);
    transfer(8'h3d, 3'h4, 3'h1, MED_DIV, SETTLE >> 1);
    transfer(8'h1b, 3'h4, 3'h2, SUB_DIV, 0);
    transfer(8'h19, 3'h4, 3'h0, HIGH_DIV, SETTLE);
    reg_wr(ADDR_IEN2, 8'h00);
    low_power(8'h0c, 3'h3, 3'h1);
    reg_wr(ADDR_IEN2, 8'h01);
    low_power(8'h04, 3'h3, 3'h1);
    low_power(8'h11, 3'h4, 3'h0);
    masked_then_reset();
    summarize();
  end
endmodule
